// ==== logic/acc_core.sv ====
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_core
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic raw_valid,
	input wire logic [23:0] raw_data,
	input wire logic unipolar,
	input wire logic [1:0] selectable_amp_gain,
	input wire logic off_wr_en,
	input wire logic [23:0] off_wr_data,
	input wire logic gain_wr_en,
	input wire logic [23:0] gain_wr_data,
	input wire logic cal_start,
	input wire logic [1:0] cal_kind,
	output logic [23:0] offset_correction,
	output logic [23:0] gain_correction,
	output logic [15:0] result,
	output logic result_valid,
	output logic cal_busy,
	output logic input_short,
	output logic ref_to_input
);
	// ****************************************
	// state and registers
	// ****************************************
	acc_pkg::acc_state_e state_r; // calibration sequencer
	acc_pkg::acc_state_e state_nxt;
	acc_pkg::acc_cal_e kind_r; // latched calibration kind
	logic [23:0] offset_correction_r; // signed offset
	logic [23:0] gain_correction_r; // unsigned 1.23 gain
	logic [15:0] result_r; // conversion result
	logic result_valid_r; // new result pulse

	// divider hookup
	logic div_busy;
	logic div_done;
	logic [23:0] div_q;

	// ****************************************
	// correction datapath
	// ****************************************
	// raw stays 24-bit bipolar; offset taken as two's complement
	wire signed [24:0] diff = $signed({raw_data[23], raw_data}) -
		$signed({offset_correction_r[23], offset_correction_r});
	// gain is unsigned with 23 fraction bits
	wire signed [49:0] prod = diff * $signed({1'b0, gain_correction_r});
	wire signed [49:0] scaled = prod >>> `ACC_GAIN_FRAC;
	// amplifier gain of 1, 2, 4 or 8 applied digitally
	wire signed [49:0] amp = scaled <<< selectable_amp_gain;
	wire signed [49:0] bip_v = amp >>> `ACC_BIP_SHIFT;
	// unipolar doubling folded into a shift one less
	wire signed [49:0] uni_v = amp >>> `ACC_UNI_SHIFT;
	wire amp_neg = amp[49];
	// out-of-range detection before cutting to 16 bits
	wire bip_hi = !bip_v[49] && (|bip_v[48:15]);
	wire bip_lo = bip_v[49] && !(&bip_v[48:15]);
	wire uni_hi = !uni_v[49] && (|uni_v[48:16]);
	wire [15:0] bip_code = bip_hi ? `ACC_BIP_MAX :
		bip_lo ? `ACC_BIP_MIN : bip_v[15:0];
	wire [15:0] uni_code = amp_neg ? `ACC_UNI_MIN :
		uni_hi ? `ACC_UNI_MAX : uni_v[15:0];
	wire [15:0] code = unipolar ? uni_code : bip_code;

	// ****************************************
	// decode of sequencer events
	// ****************************************
	wire conv_take = raw_valid && (state_r == acc_pkg::st_idle);
	wire cal_go = cal_start && (state_r == acc_pkg::st_idle);
	wire meas_take = raw_valid && (state_r == acc_pkg::st_measure);
	wire kind_gain = kind_r[0];
	wire off_store = meas_take && !kind_gain;
	wire div_start = meas_take && kind_gain;
	// non-positive corrected value has no reciprocal: go full scale
	wire [23:0] div_in = (diff > 25'sh0) ? diff[23:0] : 24'h000000;

	assign offset_correction = offset_correction_r;
	assign gain_correction = gain_correction_r;
	assign result = result_r;
	assign result_valid = result_valid_r;
	assign cal_busy = (state_r != acc_pkg::st_idle);
	// analog steering held through the whole self sequence
	assign input_short = cal_busy && (kind_r == acc_pkg::cal_self_off);
	assign ref_to_input = cal_busy && (kind_r == acc_pkg::cal_self_gain);

	// ****************************************
	// sequencer next state
	// ****************************************
	// first conversion after switching settles, second is measured
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			acc_pkg::st_idle:
				if (cal_start)
					state_nxt = acc_pkg::st_settle;
			acc_pkg::st_settle:
				if (raw_valid)
					state_nxt = acc_pkg::st_measure;
			acc_pkg::st_measure:
				if (raw_valid)
					state_nxt = kind_gain ? acc_pkg::st_divide : acc_pkg::st_idle;
			acc_pkg::st_divide:
				if (div_done)
					state_nxt = acc_pkg::st_idle;
			default:
				state_nxt = acc_pkg::st_idle;
		endcase
	end

	// sequencer state and kind
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state_r <= acc_pkg::st_idle;
			kind_r <= acc_pkg::cal_self_off;
		end
		else
		begin
			state_r <= state_nxt;
			if (cal_go)
				kind_r <= acc_pkg::acc_cal_e'(cal_kind);
		end
	end

	// ****************************************
	// correction registers
	// ****************************************
	// calibration store wins over a host write in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (srst)
			offset_correction_r <= `ACC_OFF_RST;
		else if (off_store)
			offset_correction_r <= raw_data;
		else if (off_wr_en)
			offset_correction_r <= off_wr_data;
	end

	// gain from reciprocal, or host write
	always_ff @(posedge core_clk)
	begin
		if (srst)
			gain_correction_r <= `ACC_GAIN_RST;
		else if (div_done && (state_r == acc_pkg::st_divide))
			gain_correction_r <= div_q;
		else if (gain_wr_en)
			gain_correction_r <= gain_wr_data;
	end

	// ****************************************
	// result register
	// ****************************************
	// only a finished conversion moves the result
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			result_r <= 16'h0000;
			result_valid_r <= 1'b0;
		end
		else
		begin
			result_valid_r <= conv_take;
			if (conv_take)
				result_r <= code;
		end
	end

	// reciprocal for gain calibration
	acc_recip u_recip
	(
		.core_clk(core_clk),
		.srst(srst),
		.start(div_start),
		.divisor(div_in),
		.busy(div_busy),
		.done(div_done),
		.quotient(div_q)
	);

	// ****************************************
	// checks
	// ****************************************
	sequence s_take;
		raw_valid && (state_r == acc_pkg::st_idle);
	endsequence

	sequence s_off_meas;
		raw_valid && (state_r == acc_pkg::st_measure) && !kind_r[0];
	endsequence

	sequence s_div_go;
		raw_valid && (state_r == acc_pkg::st_measure) && kind_r[0];
	endsequence

	a_reset_loads: assert property (@(posedge core_clk) disable iff (srst)
		$past(srst) |-> (offset_correction_r == `ACC_OFF_RST &&
		gain_correction_r == `ACC_GAIN_RST))
		else $error("correction reset values wrong");

	a_result_hold: assert property (@(posedge core_clk) disable iff (srst)
		!conv_take |=> $stable(result_r) && !result_valid_r)
		else $error("result moved without conversion");

	a_uni_floor: assert property (@(posedge core_clk) disable iff (srst)
		s_take ##0 (unipolar && diff[24]) |=>
		result_r == `ACC_UNI_MIN)
		else $error("negative unipolar value not clamped");

	a_bip_sat: assert property (@(posedge core_clk) disable iff (srst)
		s_take ##0 (!unipolar && !amp[49] && (|amp[48:23])) |=> result_r == `ACC_BIP_MAX)
		else $error("bipolar overflow not saturated");

	// underflow judged from the amplified value amp, not from the range flags
	a_bip_floor: assert property (@(posedge core_clk) disable iff (srst)
		s_take ##0 (!unipolar && amp[49] && !(&amp[48:23])) |=> result_r == `ACC_BIP_MIN)
		else $error("bipolar underflow not saturated");

	a_short_held: assert property (@(posedge core_clk) disable iff (srst)
		cal_go ##0 (cal_kind == 2'h0) |=> input_short && !ref_to_input && cal_busy)
		else $error("inputs not shorted in self offset");

	// reference steering follows the latched kind of a new run
	a_ref_held: assert property (@(posedge core_clk) disable iff (srst)
		cal_go ##0 (cal_kind == 2'h1) |=> ref_to_input && !input_short && cal_busy)
		else $error("reference not steered in self gain");

	a_offset_store: assert property (@(posedge core_clk) disable iff (srst)
		s_off_meas |=> offset_correction_r == $past(raw_data) &&
		state_r == acc_pkg::st_idle)
		else $error("offset not stored after measure");

	a_div_bound: assert property (@(posedge core_clk) disable iff (srst)
		s_div_go ##1 div_busy |-> ##[47:48] div_done)
		else $error("reciprocal not finished in time");

	a_gain_store: assert property (@(posedge core_clk) disable iff (srst)
		(div_done && state_r == acc_pkg::st_divide) |=>
		gain_correction_r == $past(div_q) && !cal_busy)
		else $error("gain not stored after divide");

	a_host_write: assert property (@(posedge core_clk) disable iff (srst)
		(off_wr_en && !off_store) |=> offset_correction_r == $past(off_wr_data))
		else $error("host offset write lost");
endmodule

// ==== logic/acc_defines.svh ====
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// ****************************************
// correction register reset values
// ****************************************
`define ACC_OFF_RST 24'h000000
`define ACC_GAIN_RST 24'h800000

// ****************************************
// datapath field positions and limits
// ****************************************
`define ACC_GAIN_FRAC 23
`define ACC_BIP_SHIFT 8
`define ACC_UNI_SHIFT 7
`define ACC_BIP_MAX 16'h7fff
`define ACC_BIP_MIN 16'h8000
`define ACC_UNI_MAX 16'hffff
`define ACC_UNI_MIN 16'h0000
`define ACC_GAIN_MAX 24'hffffff

// ****************************************
// reciprocal divider timing
// ****************************************
`define ACC_DIV_STEPS 6'h2f
`define ACC_RECIP_NUM 47'h400000000000

`endif

// ==== logic/acc_pkg.sv ====
// ****************************************
// shared types of the correction block
// ****************************************
package acc_pkg;
	// calibration sequencer states, gray along idle-settle-measure-divide
	typedef enum logic [1:0]
	{
		st_idle = 2'h0,
		st_settle = 2'h1,
		st_measure = 2'h3,
		st_divide = 2'h2
	} acc_state_e;

	// calibration kinds: bit 0 gain, bit 1 system
	typedef enum logic [1:0]
	{
		cal_self_off = 2'h0,
		cal_self_gain = 2'h1,
		cal_sys_off = 2'h2,
		cal_sys_gain = 2'h3
	} acc_cal_e;
endpackage

// ==== logic/acc_recip.sv ====
`timescale 1ns/1ps
`include "acc_defines.svh"

// ****************************************
// sequential reciprocal: 2^46 / divisor
// ****************************************
module acc_recip
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [23:0] divisor,
	output logic busy,
	output logic done,
	output logic [23:0] quotient
);
	logic busy_r; // division in progress
	logic done_r; // one-cycle completion pulse
	logic [5:0] cnt_r; // steps left
	logic [23:0] dvs_r; // latched divisor
	logic [23:0] rem_r; // partial remainder
	logic [46:0] num_r; // numerator bits, msb first
	logic [46:0] q_r; // quotient bits so far
	logic [23:0] quotient_r; // saturated result

	// trial subtraction of one step
	wire [24:0] trial = {rem_r, num_r[46]};
	wire fits = trial >= {1'b0, dvs_r};
	wire [24:0] trial_sub = trial - {1'b0, dvs_r};
	wire [46:0] q_nxt = {q_r[45:0], fits};
	// quotient above 24 bits clamps to the largest gain
	wire q_ovf = |q_nxt[46:24];
	wire [23:0] q_sat = q_ovf ? `ACC_GAIN_MAX : q_nxt[23:0];

	assign busy = busy_r;
	assign done = done_r;
	assign quotient = quotient_r;

	// restoring division, one quotient bit per cycle
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			cnt_r <= 6'h00;
			dvs_r <= 24'h000000;
			rem_r <= 24'h000000;
			num_r <= 47'h0;
			q_r <= 47'h0;
			quotient_r <= `ACC_GAIN_MAX;
		end
		else if (start && !busy_r)
		begin
			// zero divisor answers at once with full scale
			busy_r <= (divisor != 24'h000000);
			done_r <= (divisor == 24'h000000);
			quotient_r <= `ACC_GAIN_MAX;
			cnt_r <= `ACC_DIV_STEPS;
			dvs_r <= divisor;
			rem_r <= 24'h000000;
			num_r <= `ACC_RECIP_NUM;
			q_r <= 47'h0;
		end
		else if (busy_r)
		begin
			rem_r <= fits ? trial_sub[23:0] : trial[23:0];
			q_r <= q_nxt;
			num_r <= {num_r[45:0], 1'b0};
			cnt_r <= cnt_r - 6'h01;
			busy_r <= (cnt_r != 6'h01);
			done_r <= (cnt_r == 6'h01);
			if (cnt_r == 6'h01)
				quotient_r <= q_sat;
		end
		else
			done_r <= 1'b0;
	end
endmodule

// ==== verification/acc_filter_model.sv ====
`timescale 1ns/1ps

// ****************************************
// decimation filter stand-in
// ****************************************
module acc_filter_model
(
	input wire logic core_clk,
	output logic raw_valid,
	output logic [23:0] raw_data
);
	// idle cycles before each word, zero is prompt
	int gap = 0;

	// quiet filter at time zero
	initial
	begin
		raw_valid = 1'b0;
		raw_data = 24'h000000;
	end

	// one word, one pulse, after gap idle cycles (2 for cal words, 0 for normal words)
	task automatic push(input logic [23:0] d);
		repeat (gap) @(posedge core_clk);
		raw_valid <= 1'b1;
		raw_data <= d;
		@(posedge core_clk);
		raw_valid <= 1'b0;
		raw_data <= ~d; // stale word not held
	endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps

// ****************************************
// correction block testbench
// ****************************************
module testbench;
	logic core_clk, srst, raw_valid, unipolar, off_wr_en, gain_wr_en, cal_start;
	logic [23:0] raw_data, off_wr_data, gain_wr_data, offset_correction, gain_correction;
	logic [1:0] selectable_amp_gain, cal_kind;
	logic [15:0] result;
	logic result_valid, cal_busy, input_short, ref_to_input;
	logic [23:0] e_off, e_gain; // expected correction registers
	logic [23:0] tab [6] = '{24'h000400, 24'h7fffff, 24'h800000, 24'hfff000, 24'h012345, 24'hffffff};
	int failures, checks;

	acc_core i_dut (.core_clk, .srst, .raw_valid, .raw_data, .unipolar, .selectable_amp_gain,
		.off_wr_en, .off_wr_data, .gain_wr_en, .gain_wr_data, .cal_start, .cal_kind,
		.offset_correction, .gain_correction, .result, .result_valid, .cal_busy,
		.input_short, .ref_to_input);
	acc_filter_model i_filt (.core_clk, .raw_valid, .raw_data);

	// 125 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// compare and count
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// expected result from stored corrections
	function automatic logic [15:0] model(logic [23:0] raw, logic u, logic [1:0] s);
		longint p;
		p = ((longint'(signed'(raw)) - longint'(signed'(e_off))) * longint'(e_gain)) >>> 23;
		p = p <<< s;
		if (u)
		begin
			p = (p < 0) ? 0 : p >>> 7;
			p = (p > 65535) ? 65535 : p;
		end
		else
		begin
			p = p >>> 8;
			p = (p > 32767) ? 32767 : (p < -32768) ? -32768 : p;
		end
		return p[15:0];
	endfunction

	// one conversion, then its result
	task automatic conv(input logic [23:0] raw, input logic u, input logic [1:0] s);
		@(posedge core_clk);
		unipolar <= u;
		selectable_amp_gain <= s;
		i_filt.push(raw);
		#1;
		chk(result_valid, 1, "valid");
		chk(result, model(raw, u, s), "result");
	endtask

	// all table words in both modes, amp gain from the low bits of the loop index
	task automatic run_table(input string name);
		for (int i = 0; i < 12; i++)
			conv(tab[i % 6], i / 6, i[1:0]);
		$display("test %s done", name);
	endtask

	// host writes both corrections; result must hold
	task automatic wr(input logic [23:0] o, input logic [23:0] g);
		logic [15:0] old;
		old = result;
		@(posedge core_clk);
		off_wr_en <= 1'b1;
		off_wr_data <= o;
		gain_wr_en <= 1'b1;
		gain_wr_data <= g;
		// mode bits change too; result must still hold
		unipolar <= ~unipolar;
		selectable_amp_gain <= selectable_amp_gain + 2'h1;
		@(posedge core_clk);
		off_wr_en <= 1'b0;
		gain_wr_en <= 1'b0;
		#1;
		e_off = o;
		e_gain = g;
		chk(offset_correction, o, "off wr");
		chk(gain_correction, g, "gain wr");
		chk(result, old, "held");
		$display("test host write done");
	endtask

	// calibration run: settle word, measured word, bounded wait
	task automatic cal(input logic [1:0] k, input logic [23:0] settle, input logic [23:0] meas);
		longint d;
		int n;
		logic [15:0] old;
		old = result;
		@(posedge core_clk);
		cal_start <= 1'b1;
		cal_kind <= k;
		@(posedge core_clk);
		cal_start <= 1'b0;
		#1;
		chk(cal_busy, 1, "busy");
		chk(input_short, k == 2'h0, "short");
		chk(ref_to_input, k == 2'h1, "ref");
		// a second start while busy is ignored
		@(posedge core_clk);
		cal_start <= 1'b1;
		cal_kind <= ~k;
		@(posedge core_clk);
		cal_start <= 1'b0;
		#1;
		chk(input_short, k == 2'h0, "short kept");
		chk(ref_to_input, k == 2'h1, "ref kept");
		i_filt.gap = 2;
		i_filt.push(settle);
		#1;
		chk(result_valid, 0, "cal word");
		i_filt.push(meas);
		i_filt.gap = 0;
		#1;
		n = 0;
		while (cal_busy === 1'b1 && n < 60)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		d = longint'(signed'(meas)) - longint'(signed'(e_off));
		if (!k[0])
			e_off = meas;
		else
			e_gain = (d <= 0 || (64'sd1 <<< 46) / d > 24'hffffff) ? 24'hffffff : (64'sd1 <<< 46) / d;
		chk(cal_busy, 0, "cal end");
		chk(input_short, 0, "short off");
		chk(ref_to_input, 0, "ref off");
		chk(result, old, "cal held");
		chk(offset_correction, e_off, "cal off");
		chk(gain_correction, e_gain, "cal gain");
		$display("test cal %0d done", k);
	endtask

	// verdict
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// watchdog
	initial
	begin
		#200000;
		failures++;
		report_and_stop();
	end

	// main sequence
	initial
	begin
		{srst, unipolar, off_wr_en, gain_wr_en, cal_start} = 5'h10;
		{off_wr_data, gain_wr_data, selectable_amp_gain, cal_kind} = '0;
		failures = 0;
		checks = 0;
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		e_off = 24'h000000;
		e_gain = 24'h800000;
		chk(offset_correction, 24'h000000, "off rst");
		chk(gain_correction, 24'h800000, "gain rst");
		chk(cal_busy, 0, "busy rst");
		run_table("default");
		wr(24'hfff000, 24'h400000);
		run_table("host");
		cal(2'h0, 24'h000055, 24'hffff80);
		cal(2'h1, 24'h000000, e_off + 24'h600000);
		run_table("self");
		cal(2'h2, 24'h000010, 24'h000020);
		cal(2'h3, 24'h000000, 24'h7fffff);
		run_table("system");
		// reset in mid-run restores the defaults
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		e_off = 24'h000000;
		e_gain = 24'h800000;
		chk(offset_correction, e_off, "off rerst");
		chk(gain_correction, e_gain, "gain rerst");
		chk(result, 24'h000000, "result rerst");
		chk(cal_busy, 0, "busy rerst");
		$display("test reset done");
		run_table("after reset");
		report_and_stop();
	end
endmodule
